// ### pkg/pss_regs.svh
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

// ****************************************
// Organisation of the wide variant
// ****************************************
`define PSS_DATA_W    36
`define PSS_LANES     4
`define PSS_LANE_W    9
`define PSS_ADDR_W    18

// ****************************************
// Burst counter and pipeline
// ****************************************
`define PSS_BURST_W   2
`define PSS_BURST_RST 2'h0
`define PSS_SYNC_W    3
`define PSS_SYNC_RST  3'h0
`define PSS_FLAG_RST  1'b0

`endif

// ### pkg/pss_pkg.sv
package pss_pkg;

	// ****************************************
	// Operation held by the second pipeline stage
	// ****************************************
	typedef enum logic [1:0] {
		PSS_OP_NOP   = 2'b00,
		PSS_OP_READ  = 2'b01,
		PSS_OP_WRITE = 2'b10
	} pss_op_e;

endpackage : pss_pkg

// ### design/pss_burst_seq.sv
`timescale 1ns/1ps
`include "pss_regs.svh"

module pss_burst_seq #(
	parameter int BW = `PSS_BURST_W
) (
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic          load,
	input  wire logic          advance,
	input  wire logic          interleaved,
	input  wire logic [BW-1:0] base_lo,
	output logic      [BW-1:0] addr_lo
);

	// ****************************************
	// Parameter check
	// ****************************************
	if (BW < 1) begin : g_bad_bw
		$error("burst counter width must be at least one");
	end

	logic [BW-1:0] base_reg;
	logic [BW-1:0] base_next;
	logic [BW-1:0] cnt_reg;
	logic [BW-1:0] cnt_next;

	// ****************************************
	// Counter: cleared on load, stepped on advance
	// ****************************************
	always_comb begin
		base_next = base_reg;
		cnt_next  = cnt_reg;
		if (load) begin
			base_next = base_lo;
			cnt_next  = '0;
		end else if (advance) begin
			cnt_next = BW'(cnt_reg + 1'b1);
		end
		// Wraps inside the burst group in either order
		if (interleaved) begin
			addr_lo = base_next ^ cnt_next;
		end else begin
			addr_lo = BW'(base_next + cnt_next);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			base_reg <= `PSS_BURST_RST;
			cnt_reg  <= `PSS_BURST_RST;
		end else begin
			base_reg <= base_next;
			cnt_reg  <= cnt_next;
		end
	end

endmodule : pss_burst_seq

// ### design/pss_port.sv
`timescale 1ns/1ps
`include "pss_regs.svh"

// What this block does
// - The array holds 256K words of 36 bits or 512K words of 18 bits, chosen by parameters.
// - Address, command, byte selects and write data are all registered on the rising edge before use.
// - Read data leaves through an output register loaded on the rising edge.
// - While the active-low clock qualifier is high every edge is ignored by the pipeline and array; the sleep synchroniser and strap still run.
// - Reads and writes in any mix are taken on consecutive cycles with no wait or idle cycle.
// - Write data is taken one cycle before read data is driven, so a read then a write share a cycle and a write then a read leave one empty.
// - A write is asked for by the low write strobe, and only lanes whose low byte select is set are written.
// - Writes complete internally from the clock, with no write pulse from the master.
// - Three chip selects sampled on the clock select the part, and an asynchronous low output enable gates drive.
// - Output drive is turned off synchronously in the cycle after the one that carries write data.
// - Output drive is timed internally and needs no toggling of the output enable.
// - Bursts step linearly or interleaved as a strap caught after reset selects.
// - A sleep request parks the port while the array keeps its contents, and a stopped clock loses nothing.
module pss_port #(
	parameter int DATA_W = `PSS_DATA_W,
	parameter int LANES  = `PSS_LANES,
	parameter int ADDR_W = `PSS_ADDR_W
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              clock_qualifier_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              advance_or_load,
	input  wire logic              write_en_n,
	input  wire logic [LANES-1:0]  byte_lane_write_sel_n,
	input  wire logic              chip_select_low_a,
	input  wire logic              chip_select_high,
	input  wire logic              chip_select_low_b,
	input  wire logic              output_enable_n,
	input  wire logic              sleep_request,
	input  wire logic              burst_order_interleaved,
	input  wire logic [DATA_W-1:0] dq_in,
	output logic      [DATA_W-1:0] dq_out,
	output logic                   dq_oe,
	output logic                   sleep_active
);

	// ****************************************
	// Parameter checks
	// ****************************************
	localparam int LANE_W = `PSS_LANE_W;
	localparam int BW     = `PSS_BURST_W;
	localparam int DEPTH  = 1 << ADDR_W;

	if (DATA_W != LANES * LANE_W) begin : g_bad_width
		$error("data width must be nine bits per byte lane");
	end
	if (ADDR_W <= BW) begin : g_bad_addr
		$error("address must be wider than the burst counter");
	end

	// ****************************************
	// Lane merge, used by commit and forward
	// ****************************************
	function automatic logic [DATA_W-1:0] lane_merge(
		input logic [DATA_W-1:0] old_word,
		input logic [DATA_W-1:0] new_word,
		input logic [LANES-1:0]  lane_en
	);
		logic [DATA_W-1:0] res;
		res = old_word;
		for (int i = 0; i < LANES; i++) begin
			if (lane_en[i]) begin
				res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
			end
		end
		return res;
	endfunction : lane_merge

	// ****************************************
	// Declarations
	// ****************************************
	logic                   stall;
	logic [`PSS_SYNC_W-1:0] sync_reg;
	logic [`PSS_SYNC_W-1:0] sync_next;
	logic                   sleep_reg;
	logic                   sleep_next;
	logic                   strap_done_reg;
	logic                   strap_done_next;
	logic                   interleave_reg;
	logic                   interleave_next;

	logic [ADDR_W-1:0]      in_addr_reg;
	logic [ADDR_W-1:0]      in_addr_next;
	logic                   in_adv_reg;
	logic                   in_adv_next;
	logic                   in_wr_reg;
	logic                   in_wr_next;
	logic                   in_sel_reg;
	logic                   in_sel_next;
	logic [LANES-1:0]       in_bwn_reg;
	logic [LANES-1:0]       in_bwn_next;

	pss_pkg::pss_op_e       s2_op_reg;
	pss_pkg::pss_op_e       s2_op_next;
	logic [ADDR_W-1:0]      s2_addr_reg;
	logic [ADDR_W-1:0]      s2_addr_next;
	logic [LANES-1:0]       s2_bwn_reg;
	logic [LANES-1:0]       s2_bwn_next;
	logic                   burst_load;
	logic                   burst_adv;
	logic [BW-1:0]          burst_lo;

	logic                   wb_valid_reg;
	logic                   wb_valid_next;
	logic [ADDR_W-1:0]      wb_addr_reg;
	logic [ADDR_W-1:0]      wb_addr_next;
	logic [LANES-1:0]       wb_lane_reg;
	logic [LANES-1:0]       wb_lane_next;
	logic [DATA_W-1:0]      wb_data_reg;
	logic [DATA_W-1:0]      wb_data_next;
	logic [DATA_W-1:0]      out_data_reg;
	logic [DATA_W-1:0]      out_data_next;
	logic                   oe_reg;
	logic                   oe_next;
	logic [DATA_W-1:0]      rd_word;
	logic                   commit;

	logic [DATA_W-1:0]      mem [DEPTH];

	// The qualifier comes from logic on this clock, so it is used unsynchronised
	assign stall = clock_qualifier_n;

	// ****************************************
	// Sleep synchroniser and burst order strap
	// ****************************************
	always_comb begin
		sync_next       = sync_reg;
		sleep_next      = sleep_reg;
		strap_done_next = strap_done_reg;
		interleave_next = interleave_reg;
		// Sleep is asynchronous to the bus: three stages, act when the last two agree
		sync_next = {sync_reg[`PSS_SYNC_W-2:0], sleep_request};
		if (sync_reg[1] == sync_reg[2]) begin
			sleep_next = sync_reg[2];
		end
		// Strap is taken once at the first edge after reset release
		if (!strap_done_reg) begin
			strap_done_next = 1'b1;
			interleave_next = burst_order_interleaved;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_reg       <= `PSS_SYNC_RST;
			sleep_reg      <= `PSS_FLAG_RST;
			strap_done_reg <= `PSS_FLAG_RST;
			interleave_reg <= `PSS_FLAG_RST;
		end else begin
			sync_reg       <= sync_next;
			sleep_reg      <= sleep_next;
			strap_done_reg <= strap_done_next;
			interleave_reg <= interleave_next;
		end
	end

	// ****************************************
	// Input register stage
	// ****************************************
	always_comb begin
		in_addr_next = in_addr_reg;
		in_adv_next  = in_adv_reg;
		in_wr_next   = in_wr_reg;
		in_sel_next  = in_sel_reg;
		in_bwn_next  = in_bwn_reg;
		if (!stall) begin
			in_addr_next = addr;
			in_adv_next  = advance_or_load;
			in_wr_next   = !write_en_n;
			in_bwn_next  = byte_lane_write_sel_n;
			// Selects are sampled here, so decode lands a cycle after the pins
			in_sel_next  = !chip_select_low_a && chip_select_high && !chip_select_low_b;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			in_addr_reg <= '0;
			in_adv_reg  <= `PSS_FLAG_RST;
			in_wr_reg   <= `PSS_FLAG_RST;
			in_sel_reg  <= `PSS_FLAG_RST;
			in_bwn_reg  <= '1;
		end else begin
			in_addr_reg <= in_addr_next;
			in_adv_reg  <= in_adv_next;
			in_wr_reg   <= in_wr_next;
			in_sel_reg  <= in_sel_next;
			in_bwn_reg  <= in_bwn_next;
		end
	end

	// ****************************************
	// Command decode and burst stepping
	// ****************************************
	assign burst_load = !stall && !in_adv_reg;
	assign burst_adv  = !stall && in_adv_reg && (s2_op_reg != pss_pkg::PSS_OP_NOP);

	pss_burst_seq #(
		.BW          (BW)
	) u_burst (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.load        (burst_load),
		.advance     (burst_adv),
		.interleaved (interleave_reg),
		.base_lo     (in_addr_reg[BW-1:0]),
		.addr_lo     (burst_lo)
	);

	always_comb begin
		s2_op_next   = s2_op_reg;
		s2_addr_next = s2_addr_reg;
		s2_bwn_next  = s2_bwn_reg;
		if (!stall) begin
			s2_bwn_next = in_bwn_reg;
			if (!in_adv_reg) begin
				s2_addr_next = {in_addr_reg[ADDR_W-1:BW], burst_lo};
				if (!in_sel_reg || sleep_reg) begin
					s2_op_next = pss_pkg::PSS_OP_NOP;
				end else if (in_wr_reg) begin
					s2_op_next = pss_pkg::PSS_OP_WRITE;
				end else begin
					s2_op_next = pss_pkg::PSS_OP_READ;
				end
			end else begin
				// A burst continues the loaded command; sleep cuts it short
				s2_addr_next = {s2_addr_reg[ADDR_W-1:BW], burst_lo};
				if (sleep_reg) begin
					s2_op_next = pss_pkg::PSS_OP_NOP;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s2_op_reg   <= pss_pkg::PSS_OP_NOP;
			s2_addr_reg <= '0;
			s2_bwn_reg  <= '1;
		end else begin
			s2_op_reg   <= s2_op_next;
			s2_addr_reg <= s2_addr_next;
			s2_bwn_reg  <= s2_bwn_next;
		end
	end

	// ****************************************
	// Data stage: write buffer and read output
	// ****************************************
	always_comb begin
		rd_word = mem[s2_addr_reg];
		// Write data sits one cycle in the buffer before it reaches the array
		if (wb_valid_reg && (wb_addr_reg == s2_addr_reg)) begin
			rd_word = lane_merge(rd_word, wb_data_reg, wb_lane_reg);
		end
	end

	always_comb begin
		wb_valid_next = wb_valid_reg;
		wb_addr_next  = wb_addr_reg;
		wb_lane_next  = wb_lane_reg;
		wb_data_next  = wb_data_reg;
		out_data_next = out_data_reg;
		oe_next       = oe_reg;
		if (!stall) begin
			case (s2_op_reg)
				pss_pkg::PSS_OP_WRITE: begin
					wb_valid_next = 1'b1;
					wb_addr_next  = s2_addr_reg;
					wb_lane_next  = ~s2_bwn_reg;
					wb_data_next  = dq_in;
					oe_next       = 1'b0;
				end
				pss_pkg::PSS_OP_READ: begin
					wb_valid_next = 1'b0;
					out_data_next = rd_word;
					oe_next       = 1'b1;
				end
				default: begin
					wb_valid_next = 1'b0;
					oe_next       = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wb_valid_reg <= `PSS_FLAG_RST;
			wb_addr_reg  <= '0;
			wb_lane_reg  <= '0;
			wb_data_reg  <= '0;
			out_data_reg <= '0;
			oe_reg       <= `PSS_FLAG_RST;
		end else begin
			wb_valid_reg <= wb_valid_next;
			wb_addr_reg  <= wb_addr_next;
			wb_lane_reg  <= wb_lane_next;
			wb_data_reg  <= wb_data_next;
			out_data_reg <= out_data_next;
			oe_reg       <= oe_next;
		end
	end

	// ****************************************
	// Storage array
	// ****************************************
	// Commit is launched by the clock alone; the buffer is overwritten at the same edge
	assign commit = !stall && wb_valid_reg;

	// No reset on the array: contents survive reset, sleep and a stopped clock
	always_ff @(posedge clk_sys) begin
		if (commit) begin
			mem[wb_addr_reg] <= lane_merge(mem[wb_addr_reg], wb_data_reg, wb_lane_reg);
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign dq_out       = out_data_reg;
	// Drive window comes from the pipeline; the asynchronous enable can only mask it
	assign dq_oe        = oe_reg && !output_enable_n && !sleep_reg;
	assign sleep_active = sleep_reg;

endmodule : pss_port

// ### verif/pss_port_sva.sv
`timescale 1ns/1ps
// ***
// Port checks
// ***
module pss_port_sva #(
	parameter int DATA_W = 36,
	parameter int LANES  = 4,
	parameter int ADDR_W = 18
) (
	input wire logic              clk_sys,
	input wire logic              rst_n,
	input wire logic              clock_qualifier_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              advance_or_load,
	input wire logic              write_en_n,
	input wire logic [LANES-1:0]  byte_lane_write_sel_n,
	input wire logic              chip_select_low_a,
	input wire logic              chip_select_high,
	input wire logic              chip_select_low_b,
	input wire logic              output_enable_n,
	input wire logic              sleep_request,
	input wire logic              burst_order_interleaved,
	input wire logic [DATA_W-1:0] dq_in,
	input wire logic [DATA_W-1:0] dq_out,
	input wire logic              dq_oe,
	input wire logic              sleep_active
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire logic sel = !chip_select_low_a && chip_select_high && !chip_select_low_b;
	wire logic ld  = !clock_qualifier_n && !advance_or_load && !sleep_active;
	property p_hold;
		clock_qualifier_n |=> $stable(dq_out);
	endproperty
	chk_read_drive: assert property (ld && sel && write_en_n ##1 !clock_qualifier_n[*2] |=> dq_oe || output_enable_n || sleep_active)
		else $error("read slot not driven");
	chk_write_hiz: assert property (ld && sel && !write_en_n ##1 !clock_qualifier_n[*2] |=> !dq_oe)
		else $error("driving in write slot");
	chk_nop_quiet: assert property (ld && !sel ##1 !clock_qualifier_n[*2] |=> !dq_oe)
		else $error("deselected slot driven");
	chk_stall_hold: assert property (p_hold)
		else $error("output moved on ignored edge");
	chk_oe_mask: assert property (output_enable_n |-> !dq_oe)
		else $error("drive with output enable off");
	chk_sleep_mask: assert property (sleep_active |-> !dq_oe)
		else $error("drive while asleep");
	chk_sleep_entry: assert property (sleep_request[*6] |-> sleep_active)
		else $error("sleep not entered");
	chk_sleep_exit: assert property (!sleep_request[*6] |-> !sleep_active)
		else $error("sleep not left");
	cover property (ld && sel && write_en_n);
	cover property (ld && sel && !write_en_n);
	cover property (clock_qualifier_n[*3]);
endmodule : pss_port_sva

bind pss_port pss_port_sva #(.DATA_W(DATA_W), .LANES(LANES), .ADDR_W(ADDR_W)) u_sva (
	.clk_sys(clk_sys), .rst_n(rst_n), .clock_qualifier_n(clock_qualifier_n), .addr(addr),
	.advance_or_load(advance_or_load), .write_en_n(write_en_n), .byte_lane_write_sel_n(byte_lane_write_sel_n),
	.chip_select_low_a(chip_select_low_a), .chip_select_high(chip_select_high),
	.chip_select_low_b(chip_select_low_b), .output_enable_n(output_enable_n), .sleep_request(sleep_request),
	.burst_order_interleaved(burst_order_interleaved), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
	.sleep_active(sleep_active));

// ### verif/pss_master_model.sv
`timescale 1ns/1ps
// ***
// Bus master write data
// ***
module pss_master_model (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        clock_qualifier_n,
	input wire logic        advance_or_load,
	input wire logic        write_en_n,
	input wire logic        chip_select_low_a,
	input wire logic        chip_select_high,
	input wire logic        chip_select_low_b,
	input wire logic [5:0]  addr,
	output logic     [35:0] dq_in
);
	logic       slot_reg = 1'b0;
	logic       burst_wr = 1'b0;
	logic [5:0] word_reg = 6'h00;
	logic [5:0] wcount   = 6'h00;
	wire logic  ld_wr = !advance_or_load && !write_en_n && !chip_select_low_a && chip_select_high && !chip_select_low_b;
	// A burst beat carries data only when the load that opened the burst was a selected write
	wire logic  wr    = advance_or_load ? burst_wr : ld_wr;
	// Counter survives reset so the bench can mirror it; idle slots invert so stale data never matches
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			slot_reg <= 1'b0;
			burst_wr <= 1'b0;
			dq_in    <= 36'h0;
		end else if (!clock_qualifier_n) begin
			dq_in <= slot_reg ? {6{word_reg}} : ~dq_in;
			slot_reg <= wr;
			if (!advance_or_load) burst_wr <= ld_wr;
			word_reg <= addr ^ wcount;
			wcount <= wcount + {5'h0, wr};
		end
	end
endmodule : pss_master_model

// ### verif/testbench.sv
`timescale 1ns/1ps
// ***
// Bench
// ***
module testbench;
	typedef struct packed {
		logic       adv;
		logic       we_n;
		logic [5:0] a;
		logic [3:0] bw_n;
		logic [2:0] cs;
	} pss_row_s;
	logic        clk_sys, rst_n, clock_qualifier_n, advance_or_load, write_en_n, output_enable_n;
	logic        chip_select_low_a, chip_select_high, chip_select_low_b, sleep_request;
	logic        burst_order_interleaved, dq_oe, sleep_active, live, lw, zz;
	logic [5:0]  addr, base, ea, wn;
	logic [3:0]  byte_lane_write_sel_n;
	logic [35:0] dq_in, dq_out, exp_n, e1, e2, e3, wd;
	logic [35:0] mem [64];
	logic [1:0]  kind_n, k1, k2, k3, bn;
	int          fails = 0, samples_checked = 0, cyc = 0, i, r;
	pss_row_s    rows [16] = '{
		'{1'h0, 1'h0, 6'h05, 4'h0, 3'h2}, '{1'h0, 1'h1, 6'h05, 4'hF, 3'h2},
		'{1'h0, 1'h0, 6'h05, 4'hA, 3'h2}, '{1'h0, 1'h1, 6'h05, 4'hF, 3'h2},
		'{1'h0, 1'h0, 6'h06, 4'h0, 3'h0}, '{1'h1, 1'h1, 6'h06, 4'hF, 3'h0},
		'{1'h0, 1'h1, 6'h06, 4'hF, 3'h2}, '{1'h0, 1'h0, 6'h07, 4'h0, 3'h6},
		'{1'h0, 1'h0, 6'h01, 4'h0, 3'h3}, '{1'h0, 1'h1, 6'h07, 4'hF, 3'h2},
		'{1'h0, 1'h0, 6'h01, 4'h5, 3'h2}, '{1'h0, 1'h1, 6'h01, 4'hF, 3'h2},
		'{1'h0, 1'h1, 6'h05, 4'hF, 3'h2}, '{1'h1, 1'h1, 6'h00, 4'hF, 3'h2},
		'{1'h1, 1'h1, 6'h00, 4'hF, 3'h2}, '{1'h1, 1'h1, 6'h00, 4'hF, 3'h2}};

	pss_port #(.ADDR_W(6)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .clock_qualifier_n(clock_qualifier_n), .addr(addr),
		.advance_or_load(advance_or_load), .write_en_n(write_en_n), .byte_lane_write_sel_n(byte_lane_write_sel_n),
		.chip_select_low_a(chip_select_low_a), .chip_select_high(chip_select_high),
		.chip_select_low_b(chip_select_low_b), .output_enable_n(output_enable_n), .sleep_request(sleep_request),
		.burst_order_interleaved(burst_order_interleaved), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.sleep_active(sleep_active));
	pss_master_model u_master (
		.clk_sys(clk_sys), .rst_n(rst_n), .clock_qualifier_n(clock_qualifier_n), .addr(addr),
		.advance_or_load(advance_or_load), .write_en_n(write_en_n), .chip_select_low_a(chip_select_low_a),
		.chip_select_high(chip_select_high), .chip_select_low_b(chip_select_low_b), .dq_in(dq_in));

	task automatic results;
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] s);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// Model is updated when the command is issued, so a read behind a pending write expects new data
	task automatic op(input pss_row_s w);
		@(posedge clk_sys);
		advance_or_load <= w.adv;
		write_en_n <= w.we_n;
		addr <= w.a;
		byte_lane_write_sel_n <= w.bw_n;
		{chip_select_low_a, chip_select_high, chip_select_low_b} <= w.cs;
		if (!w.adv) begin
			base = w.a;
			bn = 2'h0;
			live = w.cs == 3'h2 && !zz;
			lw = !w.we_n;
		end else begin
			bn = bn + 2'h1;
		end
		ea = {base[5:2], burst_order_interleaved ? base[1:0] ^ bn : base[1:0] + bn};
		if (live && lw) begin
			wd = {6{w.a ^ wn}};
			wn = wn + 6'h01;
			for (int j = 0; j < 4; j++) if (!w.bw_n[j]) mem[ea][9*j +: 9] = wd[9*j +: 9];
		end
		kind_n <= !live ? 2'h0 : lw ? 2'h2 : 2'h1;
		exp_n <= mem[ea];
	endtask : op

	task automatic idle(input int n);
		repeat (n) op('{1'h0, 1'h1, 6'h00, 4'hF, 3'h0});
	endtask : idle

	task automatic wait_sleep(input logic v);
		for (int j = 0; j < 6 && sleep_active !== v; j++) @(negedge clk_sys);
		chk("sleep", 36'(v), 36'(sleep_active));
	endtask : wait_sleep

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			k1 <= 2'h0;
			k2 <= 2'h0;
			k3 <= 2'h0;
		end else if (!clock_qualifier_n) begin
			// kind_n stands for the edge that takes the command, so three stages reach the data slot
			k1 <= kind_n;
			e1 <= exp_n;
			k2 <= k1;
			e2 <= e1;
			k3 <= k2;
			e3 <= e2;
		end
	end

	always @(negedge clk_sys) begin
		if (rst_n) begin
			chk("dq_oe", 36'(k3 == 2'h1 && !output_enable_n), 36'(dq_oe));
			if (k3 == 2'h1) chk("dq_out", e3, dq_out);
		end
	end

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			results();
		end
	end

	initial begin
		rst_n = 1'b0;
		clock_qualifier_n = 1'b0;
		output_enable_n = 1'b0;
		sleep_request = 1'b0;
		burst_order_interleaved = 1'b0;
		advance_or_load = 1'b0;
		write_en_n = 1'b1;
		addr = 6'h00;
		byte_lane_write_sel_n = 4'hF;
		{chip_select_low_a, chip_select_high, chip_select_low_b} = 3'h0;
		{zz, live, lw, kind_n, wn} = 11'h000;
		repeat (20) @(posedge clk_sys);
		chk("rst_dq_out", 36'h0, dq_out);
		chk("rst_dq_oe", 36'h0, 36'(dq_oe));
		rst_n <= 1'b1;
		for (i = 0; i < 16; i++) op('{1'h0, 1'h0, 6'(i), 4'h0, 3'h2});
		for (r = 0; r < 2; r++) begin
			foreach (rows[i]) op(rows[i]);
			// Write burst with its own lane selects per beat, then read the group back
			op('{1'h0, 1'h0, 6'h09, 4'h0, 3'h2});
			repeat (3) op('{1'h1, 1'h0, 6'h00, 4'h6, 3'h2});
			op('{1'h0, 1'h1, 6'h09, 4'hF, 3'h2});
			repeat (3) op('{1'h1, 1'h1, 6'h00, 4'hF, 3'h2});
			idle(3);
			if (r == 0) begin
				op('{1'h0, 1'h0, 6'h0A, 4'h0, 3'h2});
				op('{1'h0, 1'h1, 6'h0A, 4'hF, 3'h2});
				@(posedge clk_sys);
				clock_qualifier_n <= 1'b1;
				repeat (3) @(posedge clk_sys);
				clock_qualifier_n <= 1'b0;
				idle(3);
				output_enable_n <= 1'b1;
				op(rows[1]);
				// The read's data slot is the third edge on, so the enable must stay off through it
				idle(4);
				output_enable_n <= 1'b0;
				sleep_request <= 1'b1;
				wait_sleep(1'b1);
				zz = 1'b1;
				op(rows[1]);
				idle(3);
				sleep_request <= 1'b0;
				wait_sleep(1'b0);
				zz = 1'b0;
				op(rows[1]);
				idle(3);
				// Strap is only caught after a reset, so interleaved order needs a second one
				@(posedge clk_sys);
				rst_n <= 1'b0;
				burst_order_interleaved <= 1'b1;
				repeat (20) @(posedge clk_sys);
				chk("rst2_dq_out", 36'h0, dq_out);
				chk("rst2_dq_oe", 36'h0, 36'(dq_oe));
				chk("rst2_sleep", 36'h0, 36'(sleep_active));
				rst_n <= 1'b1;
			end
		end
		results();
	end
endmodule : testbench
